// ==== pulse_counter_pkg.sv ====
// register map, field layout and reset values of the pulse counter register side
package pulse_counter_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  // staged registers that cross into the counter domain
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] CMD_OFFSET = 8'h04;
  localparam logic [7:0] TOP_RELOAD_BUFFER_OFFSET = 8'h1c;
  // register side proper
  localparam logic [7:0] HOLD_OFFSET = 8'h2c;
  localparam logic [7:0] BUSY_OFFSET = 8'h30;
  localparam logic [7:0] AUX_OFFSET = 8'h38;
  localparam logic [7:0] INSEL_OFFSET = 8'h3c;
  // update_hold_control fields
  localparam int HOLD_BIT = 0;
  localparam logic HOLD_RESET = 1'h0;
  // sync_busy_flags fields
  localparam int BUSY_CTRL_BIT = 0;
  localparam int BUSY_CMD_BIT = 1;
  localparam int BUSY_TOP_RELOAD_BUFFER_BIT = 2;
  localparam int BUSY_W = 3;
  localparam logic [2:0] BUSY_RESET = 3'h0;
  // auxiliary_count_value fields
  localparam int AUX_W = 16;
  localparam logic [15:0] AUX_RESET = 16'h0000;
  // input_source_select fields
  localparam int IN0_SEL_LSB = 0;
  localparam int IN0_EN_BIT = 4;
  localparam int IN1_SEL_LSB = 6;
  localparam int IN1_EN_BIT = 10;
  localparam int SEL_W = 2;
  localparam int INSEL_W = 11;
  localparam logic [10:0] INSEL_WRITE_MASK = 11'h4d3;
  localparam logic [10:0] INSEL_RESET = 11'h000;
  // staged register widths and resets
  localparam int TOP_RELOAD_BUFFER_W = 16;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] CMD_RESET = 32'h0000_0000;
  localparam logic [15:0] TOP_RELOAD_BUFFER_RESET = 16'h00ff;
  // reflex network width and counter domain clock ratio
  localparam int CHANNELS = 4;
  localparam int LF_DIV = 8;
endpackage : pulse_counter_pkg

// ==== lf_tick_divider.sv ====
// divider that marks each low-frequency counter clock edge with a one-cycle enable
`timescale 1ns/10ps
module lf_tick_divider #(
  parameter int DIV = pulse_counter_pkg::LF_DIV
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // one-cycle enable, once every DIV cycles
  output logic tick
);
  localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);

  logic [CW-1:0] count_r;

  // free-running count, wraps at the division ratio
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      count_r <= '0;
    end else if (count_r == LAST) begin
      count_r <= '0;
    end else begin
      count_r <= count_r + CW'(1);
    end
  end

  // registered so the enable never glitches
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      tick <= 1'b0;
    end else begin
      tick <= (count_r == LAST);
    end
  end
endmodule : lf_tick_divider

// ==== pulse_counter_sync_input_regs.sv ====
// register side of the pulse counter: update hold, sync busy, aux count, input select
//
// Operation
// R1: hold bit keeps written values on bus side
// R2: hold clear transfers writes promptly to counter
// R3: hold set leaves counter domain untouched
// R4: busy bit 2 while reload buffer syncs
// R5: busy bit 1 while command syncs
// R6: busy bit 0 while control syncs
// R7: aux count readable in bits 15:0
// R8: bit 10 routes reflex channel to input1
// R9: bits 7:6 choose input1 reflex channel
// R10: bit 4 routes reflex channel to input0
// R11: bits 1:0 choose input0 reflex channel
// R12: select values 0..3 mean channels 0..3
// R13: software writes zero to reserved bits
// R14: busy clears once value captured downstream
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/10ps
module pulse_counter_sync_input_regs #(
  parameter int LF_RATIO = pulse_counter_pkg::LF_DIV
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // register port
  input wire logic [7:0] addr,
  input wire logic [31:0] wrData,
  input wire logic wrEn,
  input wire logic rdEn,
  output logic [31:0] rdData,
  // counter domain side
  output logic [31:0] counterCtrl,
  output logic [31:0] counterCmd,
  output logic counterCmdStrobe,
  output logic [15:0] counterTopb,
  input wire logic [15:0] auxCount,
  // counter input sources
  input wire logic pinInput0,
  input wire logic pinInput1,
  input wire logic [3:0] reflexChannel,
  output logic counterInput0,
  output logic counterInput1
);
  logic lfTick;
  logic holdUpdates_r;
  logic [2:0] busy_r;
  logic [31:0] ctrlShadow_r;
  logic [31:0] cmdShadow_r;
  logic [15:0] topbShadow_r;
  logic [10:0] inSel_r;
  logic wrCtrl;
  logic wrCmd;
  logic wrTopb;
  logic transfer;
  logic [31:0] rdData_nxt;

  // channel selection, shared by both counter inputs
  function automatic logic selectSource(input logic enable, input logic [1:0] sel, input logic pin,
                                        input logic [3:0] chans);
    logic picked;
    picked = chans[sel]; // value n picks channel n [R12]
    return enable ? picked : pin;
  endfunction : selectSource

  lf_tick_divider #(
    .DIV(LF_RATIO)
  ) u_tick (
    .clock(clock),
    .rst(rst),
    .tick(lfTick)
  );

  // write decode
  assign wrCtrl = wrEn && (addr == pulse_counter_pkg::CTRL_OFFSET);
  assign wrCmd = wrEn && (addr == pulse_counter_pkg::CMD_OFFSET);
  assign wrTopb = wrEn && (addr == pulse_counter_pkg::TOP_RELOAD_BUFFER_OFFSET);
  // transfers only on a counter clock edge, and never while held
  assign transfer = lfTick && !holdUpdates_r; // [R1] [R2] [R3]

  // hold control
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      holdUpdates_r <= pulse_counter_pkg::HOLD_RESET;
    end else if (wrEn && addr == pulse_counter_pkg::HOLD_OFFSET) begin
      holdUpdates_r <= wrData[pulse_counter_pkg::HOLD_BIT];
    end
  end

  // bus side copies of the staged registers, held here while frozen [R1]
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ctrlShadow_r <= pulse_counter_pkg::CTRL_RESET;
      cmdShadow_r <= pulse_counter_pkg::CMD_RESET;
      topbShadow_r <= pulse_counter_pkg::TOP_RELOAD_BUFFER_RESET;
    end else begin
      if (wrCtrl) begin
        ctrlShadow_r <= wrData;
      end
      if (wrCmd) begin
        cmdShadow_r <= wrData;
      end
      if (wrTopb) begin
        topbShadow_r <= wrData[15:0];
      end
    end
  end

  // busy flags: a write in the transfer cycle wins, so the newer value crosses next edge
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      busy_r <= pulse_counter_pkg::BUSY_RESET;
    end else begin
      if (wrCtrl) begin
        busy_r[pulse_counter_pkg::BUSY_CTRL_BIT] <= 1'b1; // [R6]
      end else if (transfer) begin
        busy_r[pulse_counter_pkg::BUSY_CTRL_BIT] <= 1'b0; // [R14]
      end
      if (wrCmd) begin
        busy_r[pulse_counter_pkg::BUSY_CMD_BIT] <= 1'b1; // [R5]
      end else if (transfer) begin
        busy_r[pulse_counter_pkg::BUSY_CMD_BIT] <= 1'b0; // [R14]
      end
      if (wrTopb) begin
        busy_r[pulse_counter_pkg::BUSY_TOP_RELOAD_BUFFER_BIT] <= 1'b1; // [R4]
      end else if (transfer) begin
        busy_r[pulse_counter_pkg::BUSY_TOP_RELOAD_BUFFER_BIT] <= 1'b0; // [R14]
      end
    end
  end

  // counter domain copies, loaded only on a transfer edge
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      counterCtrl <= pulse_counter_pkg::CTRL_RESET;
      counterCmd <= pulse_counter_pkg::CMD_RESET;
      counterTopb <= pulse_counter_pkg::TOP_RELOAD_BUFFER_RESET;
    end else if (transfer) begin
      counterCtrl <= ctrlShadow_r; // [R2]
      counterCmd <= cmdShadow_r;
      counterTopb <= topbShadow_r;
    end
  end

  // command acts once per write, so it is a strobe rather than a level
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      counterCmdStrobe <= 1'b0;
    end else begin
      counterCmdStrobe <= transfer && busy_r[pulse_counter_pkg::BUSY_CMD_BIT]; // [R2] [R3]
    end
  end

  // input select; unused field bits are not stored, so they read back zero
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      inSel_r <= pulse_counter_pkg::INSEL_RESET;
    end else if (wrEn && addr == pulse_counter_pkg::INSEL_OFFSET) begin
      inSel_r <= wrData[10:0] & pulse_counter_pkg::INSEL_WRITE_MASK;
    end
  end

  // counter input sources, registered so outputs come from flops
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      counterInput0 <= 1'b0;
      counterInput1 <= 1'b0;
    end else begin
      counterInput0 <= selectSource(inSel_r[pulse_counter_pkg::IN0_EN_BIT], inSel_r[1:0],
                                    pinInput0, reflexChannel); // [R10] [R11]
      counterInput1 <= selectSource(inSel_r[pulse_counter_pkg::IN1_EN_BIT], inSel_r[7:6],
                                    pinInput1, reflexChannel); // [R8] [R9]
    end
  end

  // read mux; unmapped and command offsets read zero
  always_comb begin
    rdData_nxt = 32'h0000_0000;
    case (addr)
      pulse_counter_pkg::CTRL_OFFSET: rdData_nxt = ctrlShadow_r;
      pulse_counter_pkg::TOP_RELOAD_BUFFER_OFFSET: rdData_nxt = {16'h0000, topbShadow_r};
      pulse_counter_pkg::HOLD_OFFSET: rdData_nxt = {31'h0000_0000, holdUpdates_r};
      pulse_counter_pkg::BUSY_OFFSET: rdData_nxt = {29'h0000_0000, busy_r};
      pulse_counter_pkg::AUX_OFFSET: rdData_nxt = {16'h0000, auxCount}; // [R7]
      pulse_counter_pkg::INSEL_OFFSET: rdData_nxt = {21'h00_0000, inSel_r};
      default: rdData_nxt = 32'h0000_0000;
    endcase
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rdData <= 32'h0000_0000;
    end else if (rdEn) begin
      rdData <= rdData_nxt;
    end else begin
      rdData <= 32'h0000_0000;
    end
  end

  // checks
  a_hold_keeps_ctrl: assert property (@(posedge clock) disable iff (rst) // [R1]
    holdUpdates_r |=> $stable(counterCtrl) && $stable(counterTopb))
    else $error("counter domain changed while updates held");

  a_hold_no_cmd: assert property (@(posedge clock) disable iff (rst) // [R3]
    holdUpdates_r |=> !counterCmdStrobe)
    else $error("command strobe while updates held");

  a_transfer_copies: assert property (@(posedge clock) disable iff (rst) // [R2]
    (lfTick && !holdUpdates_r) |=> counterCtrl == $past(ctrlShadow_r) && counterTopb == $past(topbShadow_r))
    else $error("transfer did not copy staged values");

  a_ctrl_busy_set: assert property (@(posedge clock) disable iff (rst) // [R6]
    wrCtrl |=> busy_r[0] && ctrlShadow_r == $past(wrData))
    else $error("control write did not raise busy");

  a_cmd_busy_strobe: assert property (@(posedge clock) disable iff (rst) // [R5]
    (wrCmd && !holdUpdates_r) |=> busy_r[1] ##[1:9] counterCmdStrobe)
    else $error("command busy or strobe missing");

  a_top_reload_buffer_busy_set: assert property (@(posedge clock) disable iff (rst) // [R4]
    wrTopb |=> busy_r[2])
    else $error("reload buffer write did not raise busy");

  a_busy_clears: assert property (@(posedge clock) disable iff (rst) // [R14]
    (busy_r[0] && lfTick && !holdUpdates_r && !wrCtrl) |=> !busy_r[0] && counterCtrl == ctrlShadow_r)
    else $error("busy flag not cleared after capture");

  a_aux_read: assert property (@(posedge clock) disable iff (rst) // [R7]
    (rdEn && addr == pulse_counter_pkg::AUX_OFFSET) |=> rdData == {16'h0000, $past(auxCount)})
    else $error("aux count read mismatch");

  a_input0_route: assert property (@(posedge clock) disable iff (rst) // [R10] [R11] [R12]
    $past(inSel_r[4]) |-> counterInput0 == $past(reflexChannel[inSel_r[1:0]]))
    else $error("input0 reflex routing wrong");

  a_input1_route: assert property (@(posedge clock) disable iff (rst) // [R8] [R9]
    !$past(inSel_r[10]) |-> counterInput1 == $past(pinInput1))
    else $error("input1 pin routing wrong");

  a_input1_reflex: assert property (@(posedge clock) disable iff (rst) // [R8] [R9] [R12]
    $past(inSel_r[pulse_counter_pkg::IN1_EN_BIT]) |-> counterInput1 == $past(reflexChannel[inSel_r[7:6]]))
    else $error("input1 reflex routing wrong");

  a_input0_pin: assert property (@(posedge clock) disable iff (rst) // [R10]
    !$past(inSel_r[pulse_counter_pkg::IN0_EN_BIT]) |-> counterInput0 == $past(pinInput0))
    else $error("input0 pin routing wrong");

  // staging and busy flags of the command and reload buffer paths
  a_cmd_busy_set: assert property (@(posedge clock) disable iff (rst) // [R5]
    wrCmd |=> busy_r[1] && cmdShadow_r == $past(wrData))
    else $error("command write did not raise busy");

  a_top_reload_buffer_data: assert property (@(posedge clock) disable iff (rst) // [R4]
    wrTopb |=> topbShadow_r == $past(wrData[15:0]))
    else $error("reload buffer write not staged");

  a_busy_idle_quiet: assert property (@(posedge clock) disable iff (rst) // [R4] [R5] [R6]
    (busy_r == 3'h0 && !wrEn) |=> busy_r == 3'h0)
    else $error("busy flag rose without a write");

  a_held_busy_stays: assert property (@(posedge clock) disable iff (rst) // [R14]
    holdUpdates_r |=> (busy_r & $past(busy_r)) == $past(busy_r))
    else $error("busy flag cleared while updates held");

  a_cmd_busy_clears: assert property (@(posedge clock) disable iff (rst) // [R14]
    (busy_r[1] && lfTick && !holdUpdates_r && !wrCmd) |=>
      !busy_r[1] && counterCmdStrobe && counterCmd == cmdShadow_r)
    else $error("command busy not cleared after capture");

  a_top_reload_buffer_busy_clears: assert property (@(posedge clock) disable iff (rst) // [R14]
    (busy_r[2] && lfTick && !holdUpdates_r && !wrTopb) |=>
      !busy_r[2] && counterTopb == topbShadow_r)
    else $error("reload buffer busy not cleared after capture");

  a_strobe_needs_cmd: assert property (@(posedge clock) disable iff (rst) // [R5]
    counterCmdStrobe |-> $past(busy_r[1]))
    else $error("command strobe without a pending command");

  a_strobe_one_cycle: assert property (@(posedge clock) disable iff (rst) // [R2]
    counterCmdStrobe |=> !counterCmdStrobe)
    else $error("command strobe longer than one cycle");

  // hold bit and read port
  a_hold_write: assert property (@(posedge clock) disable iff (rst) // [R1]
    (wrEn && addr == pulse_counter_pkg::HOLD_OFFSET) |=> holdUpdates_r == $past(wrData[pulse_counter_pkg::HOLD_BIT]))
    else $error("hold bit write not taken");

  a_hold_read: assert property (@(posedge clock) disable iff (rst) // [R1]
    (rdEn && addr == pulse_counter_pkg::HOLD_OFFSET) |=> rdData == {31'h0000_0000, $past(holdUpdates_r)})
    else $error("hold bit read mismatch");

  a_busy_read: assert property (@(posedge clock) disable iff (rst) // [R4] [R5] [R6]
    (rdEn && addr == pulse_counter_pkg::BUSY_OFFSET) |=> rdData == {29'h0000_0000, $past(busy_r)})
    else $error("busy flag read mismatch");

  a_insel_reserved: assert property (@(posedge clock) disable iff (rst) // [R9] [R11]
    (rdEn && addr == pulse_counter_pkg::INSEL_OFFSET) |=>
      (rdData & ~{21'h00_0000, pulse_counter_pkg::INSEL_WRITE_MASK}) == 32'h0000_0000)
    else $error("input select reserved bits read nonzero");

  a_read_idle_zero: assert property (@(posedge clock) disable iff (rst)
    !rdEn |=> rdData == 32'h0000_0000)
    else $error("read data outside its cycle");

  c_held_release: cover property (@(posedge clock) disable iff (rst)
    holdUpdates_r && busy_r[0] ##1 !holdUpdates_r ##[1:9] !busy_r[0]);
  c_cmd_strobe: cover property (@(posedge clock) disable iff (rst) counterCmdStrobe);
  c_aux_read: cover property (@(posedge clock) disable iff (rst)
    rdEn && addr == pulse_counter_pkg::AUX_OFFSET);
  c_top_reload_buffer_cross: cover property (@(posedge clock) disable iff (rst) busy_r[2] ##1 !busy_r[2]);
  c_both_reflex: cover property (@(posedge clock) disable iff (rst)
    inSel_r[pulse_counter_pkg::IN0_EN_BIT] && inSel_r[pulse_counter_pkg::IN1_EN_BIT]);
endmodule : pulse_counter_sync_input_regs

// ==== pulse_counter_sync_input_regs_bench.sv ====
// self-checking bench for the pulse counter register side
`timescale 1ns/10ps
module pulse_counter_sync_input_regs_bench;
  localparam int LF = 4;
  logic clock, rst, wrEn, rdEn, pinInput0, pinInput1, counterCmdStrobe, counterInput0, counterInput1;
  logic [7:0] addr;
  logic [31:0] wrData, rdData, counterCtrl, counterCmd;
  logic [15:0] counterTopb, auxCount;
  logic [3:0] reflexChannel;
  logic sawStrobe;
  int failCount = 0;
  int nCompared = 0;

  pulse_counter_sync_input_regs #(.LF_RATIO(LF)) uut (
    .clock(clock), .rst(rst), .addr(addr), .wrData(wrData), .wrEn(wrEn), .rdEn(rdEn), .rdData(rdData),
    .counterCtrl(counterCtrl), .counterCmd(counterCmd), .counterCmdStrobe(counterCmdStrobe),
    .counterTopb(counterTopb), .auxCount(auxCount), .pinInput0(pinInput0), .pinInput1(pinInput1),
    .reflexChannel(reflexChannel), .counterInput0(counterInput0), .counterInput1(counterInput1)
  );

  // 250 MHz clock
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    nCompared++;
    if (seen !== exp) begin
      failCount++;
      $display("Error at %0t ns: saw %h, expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic endSim;
    if (failCount == 0 && nCompared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : endSim

  // one-cycle write strobe; the next access waits for a fresh edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    addr <= a;
    wrData <= d;
    wrEn <= 1'b1;
    @(posedge clock);
    wrEn <= 1'b0;
  endtask : wr

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock);
    addr <= a;
    rdEn <= 1'b1;
    @(posedge clock);
    rdEn <= 1'b0;
    #1 d = rdData;
  endtask : rd

  task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    rd(a, d);
    chk(d, exp);
  endtask : rdChk

  task automatic idle(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : idle

  // watches up to n edges for the one-cycle command strobe
  task automatic waitStrobe(input int n);
    sawStrobe = 1'b0;
    for (int i = 0; i < n && !sawStrobe; i++) begin
      @(posedge clock);
      #1 sawStrobe = counterCmdStrobe;
    end
  endtask : waitStrobe

  // a hang counts as a mismatch and ends the run the normal way
  initial begin
    repeat (5000) @(posedge clock);
    failCount++;
    endSim();
  end

  initial begin
    logic [31:0] v;
    rst = 1'b1;
    addr = 8'h00;
    wrData = 32'h0000_0000;
    wrEn = 1'b0;
    rdEn = 1'b0;
    auxCount = 16'h1234;
    pinInput0 = 1'b0;
    pinInput1 = 1'b0;
    reflexChannel = 4'h0;
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    // reset values and plain reads
    rdChk(pulse_counter_pkg::HOLD_OFFSET, 32'h0000_0000);
    rdChk(pulse_counter_pkg::BUSY_OFFSET, 32'h0000_0000);
    rdChk(pulse_counter_pkg::INSEL_OFFSET, 32'h0000_0000);
    rdChk(pulse_counter_pkg::AUX_OFFSET, 32'h0000_1234);
    @(posedge clock);
    auxCount <= 16'hfedc;
    rdChk(pulse_counter_pkg::AUX_OFFSET, 32'h0000_fedc);
    rdChk(8'h10, 32'h0000_0000);
    chk({16'h0000, counterTopb}, 32'h0000_00ff);
    // held writes stay on the bus side with every busy flag up
    wr(pulse_counter_pkg::HOLD_OFFSET, 32'h0000_0001);
    rdChk(pulse_counter_pkg::HOLD_OFFSET, 32'h0000_0001);
    wr(pulse_counter_pkg::CTRL_OFFSET, 32'h0000_a5c3);
    wr(pulse_counter_pkg::CMD_OFFSET, 32'h0000_0003);
    wr(pulse_counter_pkg::TOP_RELOAD_BUFFER_OFFSET, 32'h0000_1357);
    idle(4 * LF);
    rdChk(pulse_counter_pkg::BUSY_OFFSET, 32'h0000_0007);
    chk(counterCtrl, 32'h0000_0000);
    chk({16'h0000, counterTopb}, 32'h0000_00ff);
    chk({31'h0, counterCmdStrobe}, 32'h0000_0000);
    // releasing the hold lets all three cross on one tick
    wr(pulse_counter_pkg::HOLD_OFFSET, 32'h0000_0000);
    waitStrobe(2 * LF + 2);
    chk({31'h0, sawStrobe}, 32'h0000_0001);
    chk(counterCtrl, 32'h0000_a5c3);
    chk(counterCmd, 32'h0000_0003);
    chk({16'h0000, counterTopb}, 32'h0000_1357);
    rdChk(pulse_counter_pkg::BUSY_OFFSET, 32'h0000_0000);
    rdChk(pulse_counter_pkg::CMD_OFFSET, 32'h0000_0000);
    // with the hold clear a lone write crosses within one tick period
    wr(pulse_counter_pkg::CTRL_OFFSET, 32'h0000_0042);
    idle(LF + 2);
    chk(counterCtrl, 32'h0000_0042);
    rdChk(pulse_counter_pkg::BUSY_OFFSET, 32'h0000_0000);
    // a command written with the hold clear strobes once on the next tick
    wr(pulse_counter_pkg::CMD_OFFSET, 32'h0000_0005);
    waitStrobe(LF + 2);
    chk({31'h0, sawStrobe}, 32'h0000_0001);
    chk(counterCmd, 32'h0000_0005);
    rdChk(pulse_counter_pkg::BUSY_OFFSET, 32'h0000_0000);
    // every channel code on both inputs, pins opposite to the channel
    for (int s = 0; s < 4; s++) begin
      v = 32'h0000_0410 | (32'(3 - s) << 6) | 32'(s);
      wr(pulse_counter_pkg::INSEL_OFFSET, v);
      reflexChannel <= 4'h1 << s;
      pinInput0 <= 1'b0;
      pinInput1 <= 1'b1;
      idle(3);
      chk({31'h0, counterInput0}, 32'h0000_0001);
      chk({31'h0, counterInput1}, {31'h0, s == 3 - s});
      rdChk(pulse_counter_pkg::INSEL_OFFSET, v);
    end
    // enables off: pins drive the counter inputs again
    wr(pulse_counter_pkg::INSEL_OFFSET, 32'h0000_00c3);
    reflexChannel <= 4'hf;
    pinInput0 <= 1'b0;
    pinInput1 <= 1'b1;
    idle(3);
    chk({31'h0, counterInput0}, 32'h0000_0000);
    chk({31'h0, counterInput1}, 32'h0000_0001);
    rdChk(pulse_counter_pkg::INSEL_OFFSET, 32'h0000_00c3);
    endSim();
  end
endmodule : pulse_counter_sync_input_regs_bench
